//--- gpio_task_event_pkg.sv
// constants and carrier types of the pin task and event channels
package gpio_task_event_pkg;

  localparam int NUM_CHAN = 8;
  localparam int NUM_PINS = 32;
  localparam int NUM_LINKS = 16;
  localparam int ADDR_W = 12;

  // register byte offsets
  localparam logic [11:0] OFF_TASK_OUT = 12'h000;
  localparam logic [11:0] OFF_TASK_HIGH = 12'h030;
  localparam logic [11:0] OFF_TASK_LOW = 12'h060;
  localparam logic [11:0] OFF_SUB_OUT = 12'h080;
  localparam logic [11:0] OFF_SUB_HIGH = 12'h0b0;
  localparam logic [11:0] OFF_SUB_LOW = 12'h0e0;
  localparam logic [11:0] OFF_EVENT_FLAG = 12'h100;
  localparam logic [11:0] OFF_MULTI_FLAG = 12'h17c;
  localparam logic [11:0] OFF_EVENT_PUB = 12'h180;
  localparam logic [11:0] OFF_MULTI_PUB = 12'h1fc;
  localparam logic [11:0] OFF_INT_SET = 12'h304;
  localparam logic [11:0] OFF_INT_CLEAR = 12'h308;
  localparam logic [11:0] OFF_CHAN_CFG = 12'h510;
  localparam logic [11:0] CHAN_SPAN = 12'h020;

  // field positions
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_PSEL_LSB = 8;
  localparam int CFG_EDGE_LSB = 16;
  localparam int CFG_INIT_BIT = 20;
  localparam int LINK_IDX_LSB = 0;
  localparam int LINK_EN_BIT = 31;
  localparam int INT_MULTI_BIT = 31;
  localparam int TRIGGER_BIT = 0;
  localparam int FLAG_BIT = 0;

  // channel modes
  localparam logic [1:0] MODE_DISABLED = 2'h0;
  localparam logic [1:0] MODE_EVENT = 2'h1;
  localparam logic [1:0] MODE_TASK = 2'h3;

  // edge actions
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISING = 2'h1;
  localparam logic [1:0] EDGE_FALLING = 2'h2;
  localparam logic [1:0] EDGE_TOGGLE = 2'h3;

  // bus answers and reset word
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic initialOutputLevel;
    logic [1:0] edgeAction;
    logic [4:0] pinSelect;
    logic [1:0] mode;
  } chan_cfg_t;

  typedef struct packed {
    logic enable;
    logic [3:0] channelIndex;
  } link_cfg_t;

  localparam chan_cfg_t CFG_RESET = '0;
  localparam link_cfg_t LINK_RESET = '0;

endpackage

//--- gpio_task_event_channels.sv
// eight pin task and event channels with an AXI4-Lite register slave
// Contract
// - mode 0 leaves the chosen pin alone: not driven, not watched.
// - mode 1 watches the pin and raises the channel event on the edge.
// - mode 3 drives the pin; the three tasks act on it.
// - a task-mode channel owns its pin; general port writes are ignored.
// - pin_select picks one of pins 0 to 31 for tasks and event.
// - edge action 0: output task does nothing, no input event.
// - edge action 1: output task sets high; rising edge raises event.
// - edge action 2: output task drives low; falling edge raises event.
// - edge action 3: output task inverts; any change raises event.
// - entering task mode drives the pin to initial_output_level.
// - drive-high task sets the pin high, drive-low task sets it low.
// - each drive task subscribes to interconnect channel 0 to 15.
// - subscription enable 1 passes the channel trigger, 0 ignores it.
// - enabled publish registers put events onto their named channel.
// - event flag reads 1 once raised; software may write it back.
// - a separate multi-pin event flag, raised by the sense logic.
// - writing 1 to interrupt-enable-set enables; reads show enables.
// - writing 1 to interrupt-enable-clear disables; reads show enables.
`timescale 1ns/1ps
module gpio_task_event_channels
  import gpio_task_event_pkg::*;
(
  input wire logic clk_sys, // 25 MHz system clock
  input wire logic reset_n, // asynchronous reset, active low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [NUM_PINS-1:0] pinIn, // pin levels, asynchronous
  output logic [NUM_PINS-1:0] pinOut, // pin output levels
  output logic [NUM_PINS-1:0] pinOutEn, // pin drive enables
  input wire logic [NUM_PINS-1:0] gpioOut, // general port output levels
  input wire logic [NUM_PINS-1:0] gpioOutEn, // general port drive enables
  input wire logic multiPinSense, // sense logic pulse, same clock
  input wire logic [NUM_LINKS-1:0] linkIn, // interconnect channel pulses
  output logic [NUM_LINKS-1:0] linkOut, // published event pulses
  output logic irq // interrupt request, active high
);

  // register state
  chan_cfg_t cfg [NUM_CHAN];
  link_cfg_t subOut [NUM_CHAN];
  link_cfg_t subHigh [NUM_CHAN];
  link_cfg_t subLow [NUM_CHAN];
  link_cfg_t pubIn [NUM_CHAN];
  link_cfg_t pubMulti;
  logic [NUM_CHAN-1:0] eventFlag;
  logic multiFlag;
  logic [NUM_CHAN:0] intEnable;

  // bus holding state
  logic [ADDR_W-1:0] awAddr;
  logic awHeld;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic wHeld;

  // channel state
  logic [NUM_CHAN-1:0] outLevel;
  logic [NUM_PINS-1:0] pinMeta;
  logic [NUM_PINS-1:0] pinSync;
  logic [NUM_CHAN-1:0] selPrev;
  logic [NUM_CHAN-1:0] armed;

  // combinational nets
  logic wrFire;
  logic [31:0] wrMask;
  logic [31:0] wrBits;
  logic [31:0] wrMerged;
  logic [NUM_CHAN-1:0] trigOut;
  logic [NUM_CHAN-1:0] trigHigh;
  logic [NUM_CHAN-1:0] trigLow;
  logic [NUM_CHAN-1:0] cfgWrite;
  logic [NUM_CHAN-1:0] selLevel;
  logic [NUM_CHAN-1:0] inEvent;
  logic [NUM_PINS-1:0] next_pinOut;
  logic [NUM_PINS-1:0] next_pinOutEn;
  logic [NUM_LINKS-1:0] next_linkOut;

  // address lies in an eight-word array at base
  function automatic logic inArray(logic [ADDR_W-1:0] a,
                                   logic [ADDR_W-1:0] base);
    return (a >= base) && (a < base + CHAN_SPAN);
  endfunction

  // word index inside an eight-word array
  function automatic logic [2:0] wordIndex(logic [ADDR_W-1:0] a,
                                           logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] diff;
    diff = a - base;
    return diff[4:2];
  endfunction

  function automatic logic [31:0] linkWord(link_cfg_t l);
    logic [31:0] w;
    w = WORD_ZERO;
    w[LINK_EN_BIT] = l.enable;
    w[LINK_IDX_LSB +: 4] = l.channelIndex;
    return w;
  endfunction

  function automatic link_cfg_t wordLink(logic [31:0] w);
    link_cfg_t l;
    l.enable = w[LINK_EN_BIT];
    l.channelIndex = w[LINK_IDX_LSB +: 4];
    return l;
  endfunction

  function automatic logic [31:0] cfgWord(chan_cfg_t c);
    logic [31:0] w;
    w = WORD_ZERO;
    w[CFG_MODE_LSB +: 2] = c.mode;
    w[CFG_PSEL_LSB +: 5] = c.pinSelect;
    w[CFG_EDGE_LSB +: 2] = c.edgeAction;
    w[CFG_INIT_BIT] = c.initialOutputLevel;
    return w;
  endfunction

  function automatic chan_cfg_t wordCfg(logic [31:0] w);
    chan_cfg_t c;
    c.mode = w[CFG_MODE_LSB +: 2];
    c.pinSelect = w[CFG_PSEL_LSB +: 5];
    c.edgeAction = w[CFG_EDGE_LSB +: 2];
    c.initialOutputLevel = w[CFG_INIT_BIT];
    return c;
  endfunction

  function automatic logic [31:0] enableWord(logic [NUM_CHAN:0] e);
    logic [31:0] w;
    w = WORD_ZERO;
    w[NUM_CHAN-1:0] = e[NUM_CHAN-1:0];
    w[INT_MULTI_BIT] = e[NUM_CHAN];
    return w;
  endfunction

  // address belongs to the register map
  function automatic logic isMapped(logic [ADDR_W-1:0] a);
    return inArray(a, OFF_TASK_OUT) || inArray(a, OFF_TASK_HIGH) ||
           inArray(a, OFF_TASK_LOW) || inArray(a, OFF_SUB_OUT) ||
           inArray(a, OFF_SUB_HIGH) || inArray(a, OFF_SUB_LOW) ||
           inArray(a, OFF_EVENT_FLAG) || inArray(a, OFF_EVENT_PUB) ||
           inArray(a, OFF_CHAN_CFG) || a == OFF_MULTI_FLAG ||
           a == OFF_MULTI_PUB || a == OFF_INT_SET || a == OFF_INT_CLEAR;
  endfunction

  // read view of a register; tasks read zero
  function automatic logic [31:0] readReg(logic [ADDR_W-1:0] a);
    logic [31:0] w;
    w = WORD_ZERO;
    if (inArray(a, OFF_SUB_OUT)) begin
      w = linkWord(subOut[wordIndex(a, OFF_SUB_OUT)]);
    end else if (inArray(a, OFF_SUB_HIGH)) begin
      w = linkWord(subHigh[wordIndex(a, OFF_SUB_HIGH)]);
    end else if (inArray(a, OFF_SUB_LOW)) begin
      w = linkWord(subLow[wordIndex(a, OFF_SUB_LOW)]);
    end else if (inArray(a, OFF_EVENT_FLAG)) begin
      w[FLAG_BIT] = eventFlag[wordIndex(a, OFF_EVENT_FLAG)];
    end else if (inArray(a, OFF_EVENT_PUB)) begin
      w = linkWord(pubIn[wordIndex(a, OFF_EVENT_PUB)]);
    end else if (inArray(a, OFF_CHAN_CFG)) begin
      w = cfgWord(cfg[wordIndex(a, OFF_CHAN_CFG)]);
    end else if (a == OFF_MULTI_FLAG) begin
      w[FLAG_BIT] = multiFlag;
    end else if (a == OFF_MULTI_PUB) begin
      w = linkWord(pubMulti);
    end else if (a == OFF_INT_SET || a == OFF_INT_CLEAR) begin
      w = enableWord(intEnable);
    end
    return w;
  endfunction

  // bus handshake outputs
  assign s_axi_awready = !awHeld;
  assign s_axi_wready = !wHeld;
  assign s_axi_arready = !s_axi_rvalid;

  // write address and data are held until both are present
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      awHeld <= 1'b0;
      awAddr <= '0;
      wHeld <= 1'b0;
      wData <= WORD_ZERO;
      wStrb <= '0;
    end else begin
      if (s_axi_awvalid && !awHeld) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (wrFire) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && !wHeld) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end else if (wrFire) begin
        wHeld <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= isMapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= WORD_ZERO;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= readReg(s_axi_araddr);
      s_axi_rresp <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // write decode, byte-lane merge and task triggers
  always_comb begin
    wrFire = awHeld && wHeld && !s_axi_bvalid;
    for (int b = 0; b < 4; b++) begin
      wrMask[b*8 +: 8] = {8{wStrb[b]}};
    end
    wrBits = wData & wrMask;
    wrMerged = (readReg(awAddr) & ~wrMask) | wrBits;
    for (int n = 0; n < NUM_CHAN; n++) begin
      trigOut[n] = (wrFire && inArray(awAddr, OFF_TASK_OUT) &&
        wordIndex(awAddr, OFF_TASK_OUT) == 3'(n) && wrBits[TRIGGER_BIT]) ||
        (subOut[n].enable && linkIn[subOut[n].channelIndex]);
      trigHigh[n] = (wrFire && inArray(awAddr, OFF_TASK_HIGH) &&
        wordIndex(awAddr, OFF_TASK_HIGH) == 3'(n) && wrBits[TRIGGER_BIT]) ||
        (subHigh[n].enable && linkIn[subHigh[n].channelIndex]);
      trigLow[n] = (wrFire && inArray(awAddr, OFF_TASK_LOW) &&
        wordIndex(awAddr, OFF_TASK_LOW) == 3'(n) && wrBits[TRIGGER_BIT]) ||
        (subLow[n].enable && linkIn[subLow[n].channelIndex]);
      cfgWrite[n] = wrFire && inArray(awAddr, OFF_CHAN_CFG) &&
        wordIndex(awAddr, OFF_CHAN_CFG) == 3'(n);
    end
  end

  // configuration and subscription/publish registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int n = 0; n < NUM_CHAN; n++) begin
        cfg[n] <= CFG_RESET;
        subOut[n] <= LINK_RESET;
        subHigh[n] <= LINK_RESET;
        subLow[n] <= LINK_RESET;
        pubIn[n] <= LINK_RESET;
      end
      pubMulti <= LINK_RESET;
    end else if (wrFire) begin
      for (int n = 0; n < NUM_CHAN; n++) begin
        if (cfgWrite[n]) begin
          cfg[n] <= wordCfg(wrMerged);
        end
        if (inArray(awAddr, OFF_SUB_OUT) &&
            wordIndex(awAddr, OFF_SUB_OUT) == 3'(n)) begin
          subOut[n] <= wordLink(wrMerged);
        end
        if (inArray(awAddr, OFF_SUB_HIGH) &&
            wordIndex(awAddr, OFF_SUB_HIGH) == 3'(n)) begin
          subHigh[n] <= wordLink(wrMerged);
        end
        if (inArray(awAddr, OFF_SUB_LOW) &&
            wordIndex(awAddr, OFF_SUB_LOW) == 3'(n)) begin
          subLow[n] <= wordLink(wrMerged);
        end
        if (inArray(awAddr, OFF_EVENT_PUB) &&
            wordIndex(awAddr, OFF_EVENT_PUB) == 3'(n)) begin
          pubIn[n] <= wordLink(wrMerged);
        end
      end
      if (awAddr == OFF_MULTI_PUB) begin
        pubMulti <= wordLink(wrMerged);
      end
    end
  end

  // output level per channel; drive-low beats drive-high beats output task
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      outLevel <= '0;
    end else begin
      for (int n = 0; n < NUM_CHAN; n++) begin
        if (cfgWrite[n]) begin
          outLevel[n] <= wrMerged[CFG_INIT_BIT];
        end else if (cfg[n].mode == MODE_TASK) begin
          if (trigLow[n]) begin
            outLevel[n] <= 1'b0;
          end else if (trigHigh[n]) begin
            outLevel[n] <= 1'b1;
          end else if (trigOut[n]) begin
            unique case (cfg[n].edgeAction)
              EDGE_NONE: outLevel[n] <= outLevel[n];
              EDGE_RISING: outLevel[n] <= 1'b1;
              EDGE_FALLING: outLevel[n] <= 1'b0;
              EDGE_TOGGLE: outLevel[n] <= !outLevel[n];
            endcase
          end
        end
      end
    end
  end

  // pin ownership: lowest channel claiming a pin wins
  always_comb begin
    next_pinOut = gpioOut;
    next_pinOutEn = gpioOutEn;
    for (int n = NUM_CHAN - 1; n >= 0; n--) begin
      if (cfg[n].mode == MODE_TASK) begin
        next_pinOut[cfg[n].pinSelect] = outLevel[n];
        next_pinOutEn[cfg[n].pinSelect] = 1'b1;
      end else if (cfg[n].mode == MODE_EVENT) begin
        next_pinOut[cfg[n].pinSelect] = 1'b0;
        next_pinOutEn[cfg[n].pinSelect] = 1'b0;
      end
    end
  end

  // registered pin drive; disabled channels leave the port path alone
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pinOut <= '0;
      pinOutEn <= '0;
    end else begin
      pinOut <= next_pinOut;
      pinOutEn <= next_pinOutEn;
    end
  end

  // two-stage pin synchroniser
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pinMeta <= '0;
      pinSync <= '0;
    end else begin
      pinMeta <= pinIn;
      pinSync <= pinMeta;
    end
  end

  // edge detection on the selected pin
  always_comb begin
    for (int n = 0; n < NUM_CHAN; n++) begin
      selLevel[n] = pinSync[cfg[n].pinSelect];
      inEvent[n] = 1'b0;
      if (armed[n]) begin
        unique case (cfg[n].edgeAction)
          EDGE_NONE: inEvent[n] = 1'b0;
          EDGE_RISING: inEvent[n] = selLevel[n] && !selPrev[n];
          EDGE_FALLING: inEvent[n] = !selLevel[n] && selPrev[n];
          EDGE_TOGGLE: inEvent[n] = selLevel[n] != selPrev[n];
        endcase
      end
    end
  end

  // previous level; arming waits one cycle after a config write
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      selPrev <= '0;
      armed <= '0;
    end else begin
      selPrev <= selLevel;
      for (int n = 0; n < NUM_CHAN; n++) begin
        armed[n] <= (cfg[n].mode == MODE_EVENT) && !cfgWrite[n];
      end
    end
  end

  // event flags; a new event wins over a software write
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      eventFlag <= '0;
      multiFlag <= 1'b0;
    end else begin
      for (int n = 0; n < NUM_CHAN; n++) begin
        if (inEvent[n]) begin
          eventFlag[n] <= 1'b1;
        end else if (wrFire && inArray(awAddr, OFF_EVENT_FLAG) &&
                     wordIndex(awAddr, OFF_EVENT_FLAG) == 3'(n)) begin
          eventFlag[n] <= wrMerged[FLAG_BIT];
        end
      end
      if (multiPinSense) begin
        multiFlag <= 1'b1;
      end else if (wrFire && awAddr == OFF_MULTI_FLAG) begin
        multiFlag <= wrMerged[FLAG_BIT];
      end
    end
  end

  // interrupt enables: ones set or clear, zeros leave alone
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      intEnable <= '0;
    end else if (wrFire && awAddr == OFF_INT_SET) begin
      intEnable <= intEnable |
        {wrBits[INT_MULTI_BIT], wrBits[NUM_CHAN-1:0]};
    end else if (wrFire && awAddr == OFF_INT_CLEAR) begin
      intEnable <= intEnable &
        ~{wrBits[INT_MULTI_BIT], wrBits[NUM_CHAN-1:0]};
    end
  end

  // interrupt level from enabled flags
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |({multiFlag, eventFlag} & intEnable);
    end
  end

  // publish event pulses onto the interconnect
  always_comb begin
    next_linkOut = '0;
    for (int n = 0; n < NUM_CHAN; n++) begin
      if (inEvent[n] && pubIn[n].enable) begin
        next_linkOut[pubIn[n].channelIndex] = 1'b1;
      end
    end
    if (multiPinSense && pubMulti.enable) begin
      next_linkOut[pubMulti.channelIndex] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      linkOut <= '0;
    end else begin
      linkOut <= next_linkOut;
    end
  end

endmodule // gpio_task_event_channels

//--- gpio_task_event_properties.sv
// bus timing and reset release checks on the channel block ports
`timescale 1ns/1ps
module gpio_task_event_properties
  import gpio_task_event_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic reset_n, // reset, active low
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic [1:0] s_axi_bresp, // b response
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // ar address
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic [1:0] s_axi_rresp, // r response
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic [NUM_PINS-1:0] pinOutEn, // pin enables
  input wire logic [NUM_PINS-1:0] gpioOutEn // port enables
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  // both write halves taken with no answer pending; a read taken
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && !s_axi_bvalid;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  // answer timing and holding of the answers
  a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  a_bvalid_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_rvalid_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_bvalid_done: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer stuck");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer stands");
  // unmapped word and drive-high task words read as zero
  a_unmapped_read: assert property (
    s_rd_taken ##0 s_axi_araddr == 12'hffc
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == WORD_ZERO)
    else $error("unmapped read not refused");
  a_task_read_zero: assert property (
    s_rd_taken ##0 s_axi_araddr - OFF_TASK_HIGH < CHAN_SPAN
      |=> s_axi_rresp == RESP_OKAY && s_axi_rdata == WORD_ZERO)
    else $error("task word read not zero");
  // all channels unclaimed after reset, port drive passes
  a_reset_pass: assert property (
    $rose(reset_n) |=> pinOutEn == $past(gpioOutEn))
    else $error("pins claimed after reset");
endmodule // gpio_task_event_properties

bind gpio_task_event_channels gpio_task_event_properties u_props (.*);

//--- pin_partner.sv
// far-side pads: device drive, else external source, else pull-up
`timescale 1ns/1ps
module pin_partner
  import gpio_task_event_pkg::*;
(
  input wire logic [NUM_PINS-1:0] pinOut, // device levels
  input wire logic [NUM_PINS-1:0] pinOutEn, // device enables
  input wire logic [NUM_PINS-1:0] extLevel, // external levels
  input wire logic [NUM_PINS-1:0] extEn, // external enables
  output logic [NUM_PINS-1:0] pinLevel // resolved pad levels
);
  // undriven pads float up to the pull-up level
  assign pinLevel = (pinOutEn & pinOut) | (~pinOutEn & extEn & extLevel)
    | (~pinOutEn & ~extEn);
endmodule // pin_partner

//--- tb_gpio_task_event_channels.sv
// self-checking bench for the pin task and event channels
`timescale 1ns/1ps
module tb_gpio_task_event_channels
  import gpio_task_event_pkg::*;
;
  logic clk_sys, reset_n;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, multiPinSense, irq;
  logic [NUM_PINS-1:0] pinIn, pinOut, pinOutEn, gpioOut, gpioOutEn;
  logic [NUM_PINS-1:0] extLevel, extEn;
  logic [NUM_LINKS-1:0] linkIn, linkOut;
  int nMismatch = 0;
  int numChecks = 0;
  int evCount = 0;
  int multiCount = 0;
  localparam logic [11:0] RST_ADDR [9] = '{OFF_SUB_OUT, OFF_SUB_HIGH,
    OFF_SUB_LOW, OFF_EVENT_FLAG, OFF_MULTI_FLAG, OFF_EVENT_PUB,
    OFF_MULTI_PUB, OFF_INT_SET, OFF_CHAN_CFG};

  gpio_task_event_channels DUT (.*);
  pin_partner u_pins (.pinOut, .pinOutEn, .extLevel, .extEn,
    .pinLevel(pinIn));

  // 25 MHz clock
  initial begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end

  // counts publish pulses on channels 3 and 5
  always @(posedge clk_sys) begin
    if (linkOut[3]) evCount++;
    if (linkOut[5]) multiCount++;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang();
    nMismatch++;
    $display("[FAIL] %0t no bus answer", $time);
    results();
  endtask

  // k edges, then the falling edge
  task automatic tickn(input int k);
    repeat (k) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  function automatic logic [31:0] cfg(input logic [1:0] m,
    input logic [4:0] p, input logic [1:0] e, input logic i);
    return {11'h000, i, 2'h0, e, 3'h0, p, 6'h00, m};
  endfunction

  // one write, bounded wait
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
    input logic [1:0] er = RESP_OKAY);
    logic awGo, wGo, bGo;
    logic [1:0] r;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (int n = 0; n < 50; n++) begin
      @(negedge clk_sys);
      awGo = s_axi_awvalid && s_axi_awready;
      wGo = s_axi_wvalid && s_axi_wready;
      bGo = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk_sys);
      if (awGo) s_axi_awvalid <= 1'h0;
      if (wGo) s_axi_wvalid <= 1'h0;
      if (bGo) break;
    end
    s_axi_bready <= 1'h0;
    if (!bGo) hang();
    chk(32'(r), 32'(er));
  endtask

  // one read
  task automatic rdc(input logic [11:0] a, input logic [31:0] ed,
    input logic [1:0] er = RESP_OKAY);
    logic ag, go;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (int n = 0; n < 50; n++) begin
      @(negedge clk_sys);
      ag = s_axi_arvalid && s_axi_arready;
      go = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_sys);
      if (ag) s_axi_arvalid <= 1'h0;
      if (go) break;
    end
    s_axi_rready <= 1'h0;
    if (!go) hang();
    chk(d, ed);
    chk(32'(r), 32'(er));
  endtask

  // interconnect pulse, external pin level, interrupt level
  task automatic fire(input int k);
    @(posedge clk_sys);
    linkIn[k] <= 1'h1;
    @(posedge clk_sys);
    linkIn <= '0;
    tickn(2);
  endtask

  task automatic pin20(input logic v);
    @(posedge clk_sys);
    extLevel[20] <= v;
    tickn(6);
  endtask

  task automatic irqis(input logic v);
    tickn(1);
    chk(32'(irq), 32'(v));
  endtask

  // main sequence
  initial begin
    logic [31:0] w;
    reset_n = 1'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, multiPinSense} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, linkIn} = '0;
    {gpioOut, extLevel, extEn} = '0;
    s_axi_wstrb = 4'hf;
    gpioOutEn = 32'h0000_ffff;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'h1;
    tickn(2);
    chk(pinOutEn, gpioOutEn);
    foreach (RST_ADDR[i]) rdc(RST_ADDR[i], WORD_ZERO);
    wr(12'hffc, 32'h0000_0001, RESP_SLVERR);
    rdc(12'hffc, WORD_ZERO, RESP_SLVERR);
    rdc(OFF_TASK_HIGH, WORD_ZERO);
    wr(OFF_SUB_HIGH + 12'h01c, 32'h8000_000f);
    rdc(OFF_SUB_HIGH + 12'h01c, 32'h8000_000f);
    w = cfg(MODE_DISABLED, 5'h1f, EDGE_TOGGLE, 1'h1);
    wr(OFF_CHAN_CFG + 12'h01c, w);
    rdc(OFF_CHAN_CFG + 12'h01c, w);
    for (int e = 0; e < 4; e++) begin
      wr(OFF_CHAN_CFG, cfg(MODE_TASK, 5'h05, 2'(e), e != 1));
      tickn(2);
      chk(32'({pinOutEn[5], pinOut[5]}), 32'({1'h1, e != 1}));
      wr(OFF_TASK_OUT, 32'h0000_0001);
      tickn(2);
      chk(32'(pinOut[5]), 32'(e < 2));
    end
    wr(OFF_TASK_HIGH, 32'h0000_0001);
    tickn(2);
    chk(32'(pinOut[5]), 32'h0000_0001);
    wr(OFF_TASK_LOW, 32'h0000_0001);
    tickn(2);
    chk(32'(pinOut[5]), WORD_ZERO);
    wr(OFF_SUB_HIGH, 32'h8000_0007);
    fire(7);
    chk(32'(pinOut[5]), 32'h0000_0001);
    wr(OFF_SUB_LOW, 32'h0000_000f);
    fire(15);
    chk(32'(pinOut[5]), 32'h0000_0001);
    wr(OFF_SUB_LOW, 32'h8000_000f);
    fire(15);
    chk(32'(pinOut[5]), WORD_ZERO);
    @(posedge clk_sys);
    extEn <= 32'h0010_0000;
    wr(OFF_EVENT_PUB + 12'h004, 32'h8000_0003);
    wr(OFF_INT_SET, 32'h0000_0002);
    rdc(OFF_INT_CLEAR, 32'h0000_0002);
    for (int e = 0; e < 4; e++) begin
      w = cfg(MODE_EVENT, 5'h14, 2'(e), 1'h0);
      wr(OFF_CHAN_CFG + 12'h004, w);
      tickn(2);
      evCount = 0;
      pin20(1'h1);
      pin20(1'h0);
      chk(32'(evCount), 32'((e + 1) / 2));
    end
    rdc(OFF_EVENT_FLAG + 12'h004, 32'h0000_0001);
    irqis(1'h1);
    wr(OFF_INT_CLEAR, 32'h0000_0002);
    irqis(1'h0);
    wr(OFF_INT_SET, WORD_ZERO);
    rdc(OFF_INT_SET, WORD_ZERO);
    wr(OFF_INT_SET, 32'h0000_0002);
    irqis(1'h1);
    wr(OFF_EVENT_FLAG + 12'h004, WORD_ZERO);
    rdc(OFF_EVENT_FLAG + 12'h004, WORD_ZERO);
    irqis(1'h0);
    wr(OFF_CHAN_CFG + 12'h004, WORD_ZERO);
    tickn(2);
    evCount = 0;
    pin20(1'h1);
    pin20(1'h0);
    chk(32'(evCount), WORD_ZERO);
    wr(OFF_MULTI_PUB, 32'h8000_0005);
    wr(OFF_INT_SET, 32'h8000_0000);
    @(posedge clk_sys);
    multiPinSense <= 1'h1;
    @(posedge clk_sys);
    multiPinSense <= 1'h0;
    irqis(1'h1);
    chk(32'(multiCount), 32'h0000_0001);
    rdc(OFF_MULTI_FLAG, 32'h0000_0001);
    results();
  end
endmodule // tb_gpio_task_event_channels
